// [rtl/period_timer_regs.svh]
/*
 * Register indices, field positions, reset values and scaler counts of
 * the period timer. Assumes an includer that uses these as plain constants.
 */
`ifndef PERIOD_TIMER_REGS_SVH
`define PERIOD_TIMER_REGS_SVH

// Register indices; the byte address is four times the index.
`define IDX_FLAG 8'h0c
`define IDX_COUNT 8'h11
`define IDX_CONTROL 8'h12
`define IDX_MASK 8'h8c
`define IDX_LIMIT 8'h92

// Control field positions.
`define CTL_PRE_LSB 0
`define CTL_RUN_BIT 2
`define CTL_POST_LSB 3

// Flag and mask bit position.
`define FLAG_BIT 1

// Reset values.
`define RST_COUNT 8'h00
`define RST_LIMIT 8'hff
`define RST_CONTROL 7'h00

// Clock periods per counter step, less one, for each prescale code.
`define PRE_LIM_1 6'h03
`define PRE_LIM_4 6'h0f
`define PRE_LIM_16 6'h3f

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/period_timer_pkg.sv]
/*
 * Types of the period timer: control fields, register selector and the
 * state records of the prescaler and postscaler. Assumes the constants header beside it.
 */
package period_timer_pkg;
    typedef struct packed {
        logic [3:0] post_sel;
        logic run;
        logic [1:0] pre_sel;
    } ctrl_t;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_FLAG = 3'b001,
        SEL_COUNT = 3'b010,
        SEL_CONTROL = 3'b011,
        SEL_MASK = 3'b100,
        SEL_LIMIT = 3'b101
    } reg_sel_t;

    typedef struct packed {
        logic [5:0] cnt;
    } presc_t;

    typedef struct packed {
        logic [3:0] cnt;
    } post_t;
endpackage

// [rtl/period_prescaler.sv]
/*
 * Input prescaler: one step pulse per instruction cycle times the ratio.
 * Assumes sys_clk_in is the oscillator and clear comes from the same clock.
 */
`timescale 1ns/1ps
`include "period_timer_regs.svh"
module period_prescaler (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic clr_in,
    input wire logic [1:0] sel_in,
    output logic tick_out
);
    import period_timer_pkg::*;

    presc_t s_ff;
    presc_t nxt_s;
    logic [5:0] lim;

    always_comb begin
        nxt_s = s_ff;
        unique case (sel_in)
            2'b00: lim = `PRE_LIM_1;
            2'b01: lim = `PRE_LIM_4;
            default: lim = `PRE_LIM_16;
        endcase
        tick_out = run_in && !clr_in && (s_ff.cnt == lim);
        if (clr_in) begin
            nxt_s.cnt = 6'h00;
        end else if (run_in) begin
            nxt_s.cnt = tick_out ? 6'h00 : s_ff.cnt + 6'h01;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

// [rtl/period_postscaler.sv]
/*
 * Output postscaler: one terminal pulse per sel plus one match pulses.
 * Assumes match and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module period_postscaler (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic match_in,
    input wire logic clr_in,
    input wire logic [3:0] sel_in,
    output logic term_out
);
    import period_timer_pkg::*;

    post_t s_ff;
    post_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        term_out = match_in && !clr_in && (s_ff.cnt == sel_in);
        if (clr_in) begin
            nxt_s.cnt = 4'h0;
        end else if (match_in) begin
            nxt_s.cnt = term_out ? 4'h0 : s_ff.cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

// [rtl/period_timer.sv]
/*
 * Eight-bit period timer with prescaler, period match, postscaler and a
 * sticky match flag, reached over AXI4-Lite. Assumes one clock, the
 * oscillator, and a master that keeps to AXI4-Lite handshakes.
 */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "period_timer_regs.svh"
module period_timer #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic irq_out,
    output logic [7:0] period_count_out,
    output logic period_match_out
);
    import period_timer_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] count;
        logic [7:0] limit;
        ctrl_t ctrl;
        logic flag;
        logic mask;
        logic match;
        logic irq;
    } core_t;

    core_t s_ff;
    core_t nxt_s;
    reg_sel_t wsel;
    reg_sel_t rsel;
    logic do_wr;
    logic wr_cnt;
    logic wr_ctrl;
    logic wr_any;
    logic tick;
    logic post_term;

    // Maps a byte address onto a register, or none when unmapped.
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        reg_sel_t r;
        r = SEL_NONE;
        if (a[ADDR_W-1:10] == '0 && a[1:0] == 2'b00) begin
            unique case (a[9:2])
                `IDX_FLAG: r = SEL_FLAG;
                `IDX_COUNT: r = SEL_COUNT;
                `IDX_CONTROL: r = SEL_CONTROL;
                `IDX_MASK: r = SEL_MASK;
                `IDX_LIMIT: r = SEL_LIMIT;
                default: r = SEL_NONE;
            endcase
        end
        return r;
    endfunction

    period_prescaler u_pre (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .run_in(s_ff.ctrl.run),
        .clr_in(wr_any),
        .sel_in(s_ff.ctrl.pre_sel),
        .tick_out(tick)
    );

    period_postscaler u_post (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .match_in(s_ff.match),
        .clr_in(wr_any),
        .sel_in(s_ff.ctrl.post_sel),
        .term_out(post_term)
    );

    always_comb begin
        nxt_s = s_ff;
        wsel = decode(s_ff.waddr);
        rsel = decode(s_ff.waddr);
        do_wr = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
        wr_cnt = do_wr && s_ff.wstrb0 && (wsel == SEL_COUNT);
        wr_ctrl = do_wr && s_ff.wstrb0 && (wsel == SEL_CONTROL);
        wr_any = wr_cnt || wr_ctrl;
        nxt_s.match = 1'b0;
        // Write address and data are taken in either order.
        if (s_ff.awready && s_axi_awvalid_in) begin
            nxt_s.aw_held = 1'b1;
            nxt_s.waddr = s_axi_awaddr_in;
        end
        if (s_ff.wready && s_axi_wvalid_in) begin
            nxt_s.w_held = 1'b1;
            nxt_s.wdata = s_axi_wdata_in[7:0];
            nxt_s.wstrb0 = s_axi_wstrb_in[0];
        end
        // Counter steps, wrapping after it has reached the limit.
        if (tick) begin
            if (s_ff.count == s_ff.limit) begin
                nxt_s.count = 8'h00;
                nxt_s.match = 1'b1;
            end else begin
                nxt_s.count = s_ff.count + 8'h01;
            end
        end
        if (do_wr) begin
            nxt_s.aw_held = 1'b0;
            nxt_s.w_held = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            if (s_ff.wstrb0) begin
                unique case (wsel)
                    SEL_COUNT: nxt_s.count = s_ff.wdata;
                    SEL_CONTROL: nxt_s.ctrl = s_ff.wdata[6:0];
                    SEL_MASK: nxt_s.mask = s_ff.wdata[`FLAG_BIT];
                    SEL_LIMIT: nxt_s.limit = s_ff.wdata;
                    SEL_FLAG: begin
                        if (s_ff.wdata[`FLAG_BIT]) begin
                            nxt_s.flag = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // A terminal count in the clearing cycle still sets the flag.
        if (post_term) begin
            nxt_s.flag = 1'b1;
        end
        if (s_ff.bvalid && s_axi_bready_in) begin
            nxt_s.bvalid = 1'b0;
        end
        nxt_s.awready = !nxt_s.aw_held;
        nxt_s.wready = !nxt_s.w_held;
        // Read channel: one read under way at a time.
        if (s_ff.arready && s_axi_arvalid_in) begin
            rsel = decode(s_axi_araddr_in);
            nxt_s.arready = 1'b0;
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = `RESP_OKAY;
            unique case (rsel)
                SEL_FLAG: nxt_s.rdata = {6'h00, s_ff.flag, 1'b0};
                SEL_COUNT: nxt_s.rdata = s_ff.count;
                SEL_CONTROL: nxt_s.rdata = {1'b0, s_ff.ctrl};
                SEL_MASK: nxt_s.rdata = {6'h00, s_ff.mask, 1'b0};
                SEL_LIMIT: nxt_s.rdata = s_ff.limit;
                default: begin
                    nxt_s.rdata = 8'h00;
                    nxt_s.rresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_ff.rvalid && s_axi_rready_in) begin
            nxt_s.rvalid = 1'b0;
            nxt_s.arready = 1'b1;
        end
        nxt_s.irq = nxt_s.flag && nxt_s.mask;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_ff <= '0;
            s_ff.awready <= 1'b1;
            s_ff.wready <= 1'b1;
            s_ff.arready <= 1'b1;
            s_ff.count <= `RST_COUNT;
            s_ff.limit <= `RST_LIMIT;
            s_ff.ctrl <= `RST_CONTROL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign s_axi_awready_out = s_ff.awready;
    assign s_axi_wready_out = s_ff.wready;
    assign s_axi_bvalid_out = s_ff.bvalid;
    assign s_axi_bresp_out = s_ff.bresp;
    assign s_axi_arready_out = s_ff.arready;
    assign s_axi_rvalid_out = s_ff.rvalid;
    assign s_axi_rdata_out = {24'h000000, s_ff.rdata};
    assign s_axi_rresp_out = s_ff.rresp;
    assign irq_out = s_ff.irq;
    assign period_count_out = s_ff.count;
    assign period_match_out = s_ff.match;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_COUNT_INC: assert property (
        tick && !wr_cnt && s_ff.count != s_ff.limit
        |=> period_count_out == $past(s_ff.count) + 8'h01)
    else $error("Counter did not step by one.");

    AST_TICK_SPACING: assert property (
        tick |=> !tick [*3])
    else $error("Counter stepped faster than every four clocks.");

    AST_COUNT_WRAP: assert property (
        tick && !wr_cnt && s_ff.count == s_ff.limit
        |=> period_count_out == 8'h00 && period_match_out)
    else $error("Counter did not wrap with a match pulse.");

    AST_LIMIT_KEEP: assert property (
        !(do_wr && wsel == SEL_LIMIT) |=> $stable(s_ff.limit))
    else $error("Period limit changed without a write.");

    AST_POST_SETS: assert property (
        post_term |=> s_ff.flag ##0 irq_out == s_ff.mask)
    else $error("Terminal count did not raise the flag.");

    AST_STOPPED: assert property (
        !s_ff.ctrl.run && !wr_cnt |=> $stable(period_count_out))
    else $error("Counter moved while stopped.");

    AST_SCALER_CLEAR: assert property (
        wr_any |-> !tick ##1 !tick [*3])
    else $error("Prescaler not cleared by a write.");

    AST_CTRL_KEEPS_COUNT: assert property (
        wr_ctrl |=> period_count_out == $past(s_ff.count))
    else $error("Control write changed the counter.");

    AST_MATCH_PULSE: assert property (
        period_match_out |=> !period_match_out [*3])
    else $error("Match pulse longer than one clock.");

    AST_FLAG_STICKY: assert property (
        s_ff.flag && !(do_wr && wsel == SEL_FLAG && s_ff.wdata[`FLAG_BIT])
        |=> s_ff.flag)
    else $error("Match flag dropped without a clear.");

    COV_WRAP: cover property (tick && s_ff.count == s_ff.limit);
    COV_FLAG: cover property (post_term && !s_ff.flag);
    COV_CNT_WRITE: cover property (wr_cnt ##1 tick);
    COV_IRQ: cover property (!irq_out ##1 irq_out);
endmodule

// [tb/timebase_partner_model.sv]
/*
 * Model of the PWM and serial units that consume the timer base.
 * Assumes the timer's clock and reset, and its count and match outputs.
 */
`timescale 1ns/1ps
module timebase_partner_model (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] period_count_in,
    input wire logic period_match_in,
    output logic [15:0] match_total_out,
    output logic [7:0] last_count_out
);
    logic [15:0] match_total_ff;
    logic [7:0] last_count_ff;

    // Counts shift clock events and keeps the count seen at each one.
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            match_total_ff <= 16'h0000;
            last_count_ff <= 8'h00;
        end else if (period_match_in) begin
            match_total_ff <= match_total_ff + 16'h0001;
            last_count_ff <= period_count_in;
        end
    end
    assign match_total_out = match_total_ff;
    assign last_count_out = last_count_ff;
endmodule

// [tb/period_timer_tb.sv]
/*
 * Self-checking bench of the period timer over AXI4-Lite.
 * Assumes the design files and the partner model are compiled first.
 */
`timescale 1ns/1ps
`include "period_timer_regs.svh"
module period_timer_tb;
    import period_timer_pkg::*;
    localparam logic [11:0] A_FLAG = `IDX_FLAG * 4;
    localparam logic [11:0] A_CNT = `IDX_COUNT * 4;
    localparam logic [11:0] A_CTL = `IDX_CONTROL * 4;
    localparam logic [11:0] A_MASK = `IDX_MASK * 4;
    localparam logic [11:0] A_LIM = `IDX_LIMIT * 4;
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, match;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [7:0] cnt, x, last, lim;
    logic [15:0] total, m0;
    int num_errors, n_tests, n, i, j, p;

    period_timer period_timer_i (.sys_clk_in(clk), .rst_n_in(rst_n),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .irq_out(irq),
        .period_count_out(cnt), .period_match_out(match));
    timebase_partner_model timebase_partner_model_i (.sys_clk_in(clk), .rst_n_in(rst_n),
        .period_count_in(cnt), .period_match_in(match), .match_total_out(total),
        .last_count_out(last));

    always #50 clk = ~clk;

    task automatic report_and_stop;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic fail;
        num_errors++;
        report_and_stop;
    endtask

    function automatic logic [7:0] ctl(input logic [3:0] ps, input logic r, input logic [1:0] s);
        return {1'b0, ps, r, s};
    endfunction

    function automatic int ratio(input logic [1:0] s);
        return s == 2'b00 ? 1 : (s == 2'b01 ? 4 : 16);
    endfunction

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        int k;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (k == 40) fail();
        chk(bresp, er);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (k == 40) fail();
        chk(rdata, {24'h0, exp});
        chk(rresp, er);
    endtask

    task automatic wait_until(input int what);
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 3000) fail();
        end while (what == 0 ? !match : (what == 1 ? !irq : cnt === x));
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        num_errors = 0;
        n_tests = 0;
        x = 8'($urandom(32'hb329));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdc(A_CNT, 8'h00, `RESP_OKAY);
        rdc(A_LIM, 8'hff, `RESP_OKAY);
        rdc(A_CTL, 8'h00, `RESP_OKAY);
        rdc(A_FLAG, 8'h00, `RESP_OKAY);
        rdc(A_MASK, 8'h00, `RESP_OKAY);
        rdc(12'h004, 8'h00, `RESP_SLVERR);
        wr(12'h004, 8'h55, `RESP_SLVERR);
        wr(A_LIM, x, `RESP_OKAY);
        rdc(A_LIM, x, `RESP_OKAY);
        // A stopped timer holds its count, and control writes keep it.
        wr(A_CNT, x, `RESP_OKAY);
        wr(A_CTL, ctl(4'h5, 1'b0, 2'h2), `RESP_OKAY);
        repeat (50) @(posedge clk);
        rdc(A_CNT, x, `RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            lim = 8'($urandom_range(5, 1));
            wr(A_LIM, lim, `RESP_OKAY);
            rdc(A_LIM, lim, `RESP_OKAY);
            wr(A_CNT, 8'h00, `RESP_OKAY);
            wr(A_CTL, ctl(4'h0, 1'b1, i[1:0]), `RESP_OKAY);
            wait_until(0);
            wait_until(0);
            chk(n, (lim + 1) * 4 * ratio(i[1:0]));
            chk(last, 8'h00);
        end
        // Count and control writes restart a full prescale period.
        wr(A_LIM, 8'hff, `RESP_OKAY);
        for (j = 0; j < 2; j++) begin
            repeat ($urandom_range(60, 5)) @(posedge clk);
            x = 8'($urandom_range(200, 0));
            if (j == 0) wr(A_CNT, x, `RESP_OKAY);
            else wr(A_CTL, ctl(4'h0, 1'b1, 2'h2), `RESP_OKAY);
            x = cnt;
            wait_until(2);
            chk(n, 64);
            chk(cnt, x + 8'h01);
        end
        wr(A_CTL, ctl(4'h0, 1'b0, 2'h0), `RESP_OKAY);
        wr(A_LIM, 8'h01, `RESP_OKAY);
        // Earlier runs left the flag set; clear it before unmasking.
        wr(A_FLAG, 8'h02, `RESP_OKAY);
        rdc(A_FLAG, 8'h00, `RESP_OKAY);
        wr(A_MASK, 8'h02, `RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            p = i == 0 ? 0 : (i == 1 ? 15 : $urandom_range(14, 1));
            m0 = total;
            wr(A_CTL, ctl(p[3:0], 1'b1, 2'h0), `RESP_OKAY);
            wait_until(1);
            chk(total - m0, p + 1);
            repeat (40) @(posedge clk);
            rdc(A_FLAG, 8'h02, `RESP_OKAY);
            wr(A_MASK, 8'h00, `RESP_OKAY);
            repeat (2) @(posedge clk);
            chk(irq, 1'b0);
            wr(A_MASK, 8'h02, `RESP_OKAY);
            repeat (2) @(posedge clk);
            chk(irq, 1'b1);
            wr(A_CTL, ctl(p[3:0], 1'b0, 2'h0), `RESP_OKAY);
            wr(A_FLAG, 8'h02, `RESP_OKAY);
            rdc(A_FLAG, 8'h00, `RESP_OKAY);
            repeat (2) @(posedge clk);
            chk(irq, 1'b0);
        end
        report_and_stop();
    end
endmodule
